// File: wdg_top.sv
// Behaviour
// - missing falling trigger edge within trigger period pulls output low.
// - all intervals counted from internal timebase derived by own divider.
// - after power-on output held low for full reset delay.
// - output rising edge while enabled starts 16 ms ignore interval, triggers ignored.
// - ignore end opens 48 ms trigger period.
// - falling trigger edge inside trigger period restarts that period.
// - missed trigger keeps output low for 8 ms.
// - enable state changes only after band flag steady for filter time.
// - band excursions shorter than 100 us change nothing.
// - enable state change completes within 500 us of steady flag.
// - reset and watchdog share one output, low when either demands.
// - undervoltage drives output low within 33 us.
// - disabled watchdog with no low interval running keeps output high.
// - leaving disabled state runs ignore interval, then new trigger period.
`timescale 1ns/10ps
`default_nettype none
`include "wdg_defs.svh"

module wdg_top
   import wdg_pkg::*;
#(
   parameter logic [`WDG_TMR_W-1:0] RST_DELAY_TICKS = 16'(`WDG_US2TICK(`WDG_RST_DELAY_US)),
   parameter logic [`WDG_TMR_W-1:0] IGNORE_TICKS    = 16'(`WDG_US2TICK(`WDG_IGNORE_US)),
   parameter logic [`WDG_TMR_W-1:0] TRIGGER_TICKS   = 16'(`WDG_US2TICK(`WDG_TRIGGER_US)),
   parameter logic [`WDG_TMR_W-1:0] LOW_TICKS       = 16'(`WDG_US2TICK(`WDG_LOW_US))
) (
   input  wire logic   CLK,
   input  wire logic   RESET,
   input  wire logic   WD_TRIGGER_IN,
   input  wire logic   DISABLE_BAND_LEVEL,
   input  wire logic   UNDERVOLTAGE,
   output logic        SUPERVISOR_OUT_N,
   output logic        SUPERVISOR_PULL_OE,
   output logic        WD_ENABLED
);

   localparam logic [3:0]            DIV_LAST     = 4'(`WDG_DIV_CYC - 1);
   localparam logic [`WDG_TMR_W-1:0] FILTER_TICKS = 16'(`WDG_US2TICK(`WDG_FILTER_US));

   wdg_state_t             state_q;
   wdg_state_t             state_d;
   logic [3:0]             div_q;
   logic [3:0]             div_d;
   logic                   tick;
   logic                   trig_prev_q;
   logic                   trig_fall;
   logic                   en_q;
   logic                   en_d;
   logic                   out_d;
   logic [12:0]            diff_run_q;
   logic [12:0]            diff_run_d;
   wdg_tmr_cmd_t           tmr_cmd;
   wdg_tmr_cmd_t           filt_cmd;
   logic [`WDG_TMR_W-1:0]  tmr_cnt;
   logic [`WDG_TMR_W-1:0]  filt_cnt;
   logic                   tmr_done;
   logic                   filt_done;
   logic                   band_differs;

   // ****************************************************************
   // internal timebase
   // ****************************************************************
   // divider giving one tick per microsecond
   always_comb begin
      div_d = (div_q == DIV_LAST) ? 4'h0 : div_q + 4'h1;
   end

   assign tick = (div_q == DIV_LAST);

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         div_q <= 4'h0;
      end else begin
         div_q <= div_d;
      end
   end

   // ****************************************************************
   // interval timers
   // ****************************************************************
   wdg_timer #(
      .RST_VAL (RST_DELAY_TICKS)
   ) u_interval (
      .clk   (CLK),
      .rst   (RESET),
      .tick  (tick),
      .cmd   (tmr_cmd),
      .count (tmr_cnt),
      .done  (tmr_done)
   );

   wdg_timer #(
      .RST_VAL (FILTER_TICKS)
   ) u_filter (
      .clk   (CLK),
      .rst   (RESET),
      .tick  (tick),
      .cmd   (filt_cmd),
      .count (filt_cnt),
      .done  (filt_done)
   );

   // ****************************************************************
   // disable band filter
   // ****************************************************************
   // filter restarts whenever the band flag agrees with the enable state
   always_comb begin
      band_differs   = (DISABLE_BAND_LEVEL == en_q);
      filt_cmd.load  = !band_differs;
      filt_cmd.value = FILTER_TICKS;
      en_d           = en_q;
      if (band_differs && filt_done) begin
         en_d = !DISABLE_BAND_LEVEL;
      end
      // cycles the band flag has disagreed, for the timing checks
      diff_run_d = band_differs ? diff_run_q + 13'h0001 : 13'h0000;
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         en_q       <= 1'b1;
         diff_run_q <= 13'h0000;
      end else begin
         en_q       <= en_d;
         diff_run_q <= diff_run_d;
      end
   end

   // ****************************************************************
   // supervision state machine
   // ****************************************************************
   assign trig_fall = trig_prev_q && !WD_TRIGGER_IN;

   // next state and interval reload
   always_comb begin
      state_d = state_q;
      case (state_q)
         WDG_POR: begin
            if (tmr_done) begin
               state_d = en_q ? WDG_IGNORE : WDG_DISABLED;
            end
         end
         WDG_IGNORE: begin
            if (!en_q) begin
               state_d = WDG_DISABLED;
            end else if (tmr_done) begin
               state_d = WDG_TRIGGER;
            end
         end
         WDG_TRIGGER: begin
            if (!en_q) begin
               state_d = WDG_DISABLED;
            end else if (!trig_fall && tmr_done) begin
               state_d = WDG_LOWOUT;
            end
         end
         WDG_LOWOUT: begin
            if (tmr_done) begin
               state_d = en_q ? WDG_IGNORE : WDG_DISABLED;
            end
         end
         WDG_DISABLED: begin
            if (en_q) begin
               state_d = WDG_IGNORE;
            end
         end
         default: begin
            state_d = WDG_POR;
         end
      endcase
      if (UNDERVOLTAGE) begin
         state_d = WDG_POR;
      end
      tmr_cmd.load = UNDERVOLTAGE || (state_d != state_q) ||
                     (state_q == WDG_TRIGGER && trig_fall);
      case (state_d)
         WDG_IGNORE:  tmr_cmd.value = IGNORE_TICKS;
         WDG_TRIGGER: tmr_cmd.value = TRIGGER_TICKS;
         WDG_LOWOUT:  tmr_cmd.value = LOW_TICKS;
         default:     tmr_cmd.value = RST_DELAY_TICKS;
      endcase
      out_d = !(state_d == WDG_POR || state_d == WDG_LOWOUT);
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state_q     <= WDG_POR;
         trig_prev_q <= 1'b0;
      end else begin
         state_q     <= state_d;
         trig_prev_q <= WD_TRIGGER_IN;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         SUPERVISOR_OUT_N   <= 1'b0;
         SUPERVISOR_PULL_OE <= 1'b1;
         WD_ENABLED         <= 1'b1;
      end else begin
         SUPERVISOR_OUT_N   <= out_d;
         SUPERVISOR_PULL_OE <= !out_d;
         WD_ENABLED         <= en_d;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   tick_spacing_a: assert property (@(posedge CLK) disable iff (RESET)
      tick |=> !tick [*8] ##1 !tick ##1 tick)
      else $error("timebase tick spacing wrong");

   por_release_a: assert property (@(posedge CLK) disable iff (RESET)
      (state_q == WDG_POR && !tmr_done) |=> !SUPERVISOR_OUT_N)
      else $error("output released during reset delay");

   rise_ignore_a: assert property (@(posedge CLK) disable iff (RESET)
      $rose(SUPERVISOR_OUT_N) |-> (state_q == WDG_IGNORE || state_q == WDG_DISABLED))
      else $error("output rose without ignore interval");

   ignore_end_a: assert property (@(posedge CLK) disable iff (RESET)
      (state_q == WDG_IGNORE && tmr_done && en_q && !UNDERVOLTAGE)
      |=> state_q == WDG_TRIGGER && tmr_cnt == TRIGGER_TICKS)
      else $error("trigger period not opened after ignore");

   trig_restart_a: assert property (@(posedge CLK) disable iff (RESET)
      (state_q == WDG_TRIGGER && trig_fall && en_q && !UNDERVOLTAGE)
      |=> state_q == WDG_TRIGGER && tmr_cnt == TRIGGER_TICKS)
      else $error("trigger edge did not restart period");

   missed_low_a: assert property (@(posedge CLK) disable iff (RESET)
      (state_q == WDG_TRIGGER && tmr_done && !trig_fall && en_q && !UNDERVOLTAGE)
      |=> !SUPERVISOR_OUT_N && tmr_cnt == LOW_TICKS)
      else $error("missed trigger not signalled");

   low_end_a: assert property (@(posedge CLK) disable iff (RESET)
      (state_q == WDG_LOWOUT && tmr_done && en_q && !UNDERVOLTAGE)
      |=> SUPERVISOR_OUT_N && state_q == WDG_IGNORE)
      else $error("low interval end not followed by ignore");

   filter_hold_a: assert property (@(posedge CLK) disable iff (RESET)
      (en_q != $past(en_q)) |-> $past(filt_done) && $past(band_differs) && $past(diff_run_q) >= 13'h03E7)
      else $error("enable changed before filter time");

   filter_bound_a: assert property (@(posedge CLK) disable iff (RESET)
      diff_run_q < 13'h1388)
      else $error("enable change later than allowed");

   disabled_high_a: assert property (@(posedge CLK) disable iff (RESET)
      state_q == WDG_DISABLED |-> SUPERVISOR_OUT_N)
      else $error("disabled watchdog holds output low");

   uv_low_a: assert property (@(posedge CLK) disable iff (RESET)
      UNDERVOLTAGE |=> !SUPERVISOR_OUT_N)
      else $error("undervoltage did not pull output low");

   reenable_a: assert property (@(posedge CLK) disable iff (RESET)
      (state_q == WDG_DISABLED && en_q && !UNDERVOLTAGE) |=> state_q == WDG_IGNORE)
      else $error("re-enable skipped ignore interval");

   missed_c: cover property (@(posedge CLK) disable iff (RESET)
      state_q == WDG_TRIGGER ##1 state_q == WDG_LOWOUT);
   served_c: cover property (@(posedge CLK) disable iff (RESET)
      state_q == WDG_TRIGGER && trig_fall);
   disable_c: cover property (@(posedge CLK) disable iff (RESET)
      $fell(en_q));
   lowdis_c: cover property (@(posedge CLK) disable iff (RESET)
      state_q == WDG_LOWOUT ##1 state_q == WDG_DISABLED);

endmodule

`default_nettype wire

// File: wdg_defs.svh
`ifndef WDG_DEFS_SVH
`define WDG_DEFS_SVH

// ****************************************************************
// clock and internal timebase
// ****************************************************************
`define WDG_CLK_NS          100
`define WDG_TICK_NS         1000
`define WDG_DIV_CYC         (`WDG_TICK_NS / `WDG_CLK_NS)
`define WDG_US2TICK(us)     ((us) * 1000 / `WDG_TICK_NS)

// ****************************************************************
// supervision times in microseconds (nominal), undervoltage reaction also in clock cycles
// ****************************************************************
`define WDG_RST_DELAY_US    8500
`define WDG_IGNORE_US       16000
`define WDG_TRIGGER_US      48000
`define WDG_LOW_US          8000
`define WDG_FILTER_US       200
`define WDG_FILTER_MIN_US   100
`define WDG_FILTER_MAX_US   500
`define WDG_UV_REACT_US     33
`define WDG_UV_REACT_CYC    (`WDG_UV_REACT_US * 1000 / `WDG_CLK_NS)

// ****************************************************************
// timer layout
// ****************************************************************
`define WDG_TMR_W           16

`endif

// File: wdg_pkg.sv
`default_nettype none
`include "wdg_defs.svh"

package wdg_pkg;

   // supervision states
   typedef enum logic [2:0] {
      WDG_POR,
      WDG_IGNORE,
      WDG_TRIGGER,
      WDG_LOWOUT,
      WDG_DISABLED
   } wdg_state_t;

   // timer command: reload strobe and value
   typedef struct packed {
      logic                    load;
      logic [`WDG_TMR_W-1:0]   value;
   } wdg_tmr_cmd_t;

endpackage

`default_nettype wire

// File: wdg_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdg_defs.svh"

module wdg_timer
   import wdg_pkg::*;
#(
   parameter logic [`WDG_TMR_W-1:0] RST_VAL = 16'h0001
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  tick,
   input  wire wdg_tmr_cmd_t          cmd,
   output logic [`WDG_TMR_W-1:0]      count,
   output logic                       done
);

   logic [`WDG_TMR_W-1:0] cnt_q;
   logic [`WDG_TMR_W-1:0] cnt_d;

   // ****************************************************************
   // down counter on timebase ticks
   // ****************************************************************
   always_comb begin
      cnt_d = cnt_q;
      if (cmd.load) begin
         cnt_d = cmd.value;
      end else if (tick && cnt_q != '0) begin
         cnt_d = cnt_q - 16'h0001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= RST_VAL;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign count = cnt_q;
   assign done  = (cnt_q == '0); // interval elapsed

endmodule

`default_nettype wire

// File: wdg_mcu_model.sv
`timescale 1ns/10ps
`default_nettype none

// ********************************************
// supervised controller model
// ********************************************
module wdg_mcu_model (
   input  wire logic          clk,
   input  wire logic          reset_n_in,
   input  wire logic          serve,
   input  wire logic [15:0]   half_cyc,
   output logic               trig
);
   logic [15:0] cnt;

   initial begin
      trig = 1'b0;
      cnt  = 16'h0000;
   end

   // trigger toggles every half_cyc cycles, held low in reset or idle
   always @(negedge clk) begin
      if (!reset_n_in || !serve) begin
         trig <= 1'b0;
         cnt  <= 16'h0000;
      end else if (cnt >= half_cyc - 16'h0001) begin
         trig <= ~trig;
         cnt  <= 16'h0000;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule

`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import wdg_pkg::*;
   localparam logic [15:0] RD = 16'h0014;
   localparam logic [15:0] IG = 16'h0028;
   localparam logic [15:0] TR = 16'h0050;
   localparam logic [15:0] LW = 16'h001E;
   logic        clk;
   logic        reset;
   logic        trig;
   logic        band;
   logic        uv;
   logic        serve;
   logic [15:0] half;
   logic        out_n;
   logic        pull_oe;
   logic        wd_en;
   int          err_total;
   int          n_compared;
   int          cyc;

   wdg_top #(.RST_DELAY_TICKS(RD), .IGNORE_TICKS(IG), .TRIGGER_TICKS(TR), .LOW_TICKS(LW)) dut (
      .CLK(clk), .RESET(reset), .WD_TRIGGER_IN(trig), .DISABLE_BAND_LEVEL(band),
      .UNDERVOLTAGE(uv), .SUPERVISOR_OUT_N(out_n), .SUPERVISOR_PULL_OE(pull_oe), .WD_ENABLED(wd_en));

   wdg_mcu_model mcu (.clk(clk), .reset_n_in(out_n), .serve(serve), .half_cyc(half), .trig(trig));

   // ********************************************
   // checking helpers
   // ********************************************
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic print_verdict();
      if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic sig(input int w);
      return (w == 0) ? out_n : wd_en;
   endfunction

   // expected window of an interval of n ticks
   function automatic int lo_of(input int n);
      return n * 10 - 2;
   endfunction

   function automatic int hi_of(input int n);
      return (n + 1) * 10 + 5;
   endfunction

   task automatic wait_for(input int w, input logic v, input int lo, input int hi, input string nm);
      int n;
      n = 0;
      while (sig(w) !== v && n <= hi) begin
         @(negedge clk);
         n++;
      end
      check(nm, 32'(n >= lo && n <= hi), 32'h0000_0001);
   endtask

   task automatic hold_chk(input int w, input logic v, input int n, input string nm);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         @(negedge clk);
         if (sig(w) !== v) bad = 1'b1;
      end
      check(nm, 32'(bad), 32'h0000_0000);
   endtask

   // clock and cycle ceiling
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         print_verdict();
      end
   end

   // pull-down enable is the inverse of the output every cycle
   always @(negedge clk) begin
      if (!reset) check("pull_oe", 32'(pull_oe), 32'(!out_n));
   end

   // ********************************************
   // main sequence
   // ********************************************
   initial begin
      logic [15:0] tbl [3];
      int k;
      err_total = 0;
      n_compared = 0;
      cyc = 0;
      reset = 1'b1;
      band = 1'b0;
      uv = 1'b0;
      serve = 1'b0;
      half = 16'h000A;
      void'($urandom(98));
      repeat (8) @(negedge clk);
      reset = 1'b0;
      wait_for(0, 1'b1, lo_of(RD), hi_of(RD), "reset_delay");
      wait_for(0, 1'b0, lo_of(IG + TR), hi_of(IG + TR + 1), "miss_fall");
      wait_for(0, 1'b1, lo_of(LW), hi_of(LW), "low_time");
      wait_for(0, 1'b0, lo_of(IG + TR), hi_of(IG + TR + 1), "restart_ignore");
      wait_for(0, 1'b1, lo_of(LW), hi_of(LW), "low_time2");
      uv = 1'b1;
      @(negedge clk);
      check("uv_low", 32'(out_n), 32'h0000_0000);
      hold_chk(0, 1'b0, 5 + $urandom % 50, "uv_hold");
      uv = 1'b0;
      // reload happens at a free-running tick phase, so up to one tick less
      wait_for(0, 1'b1, lo_of(RD - 1), hi_of(RD), "uv_delay");
      tbl[0] = 16'h000A;
      tbl[1] = 16'h000A + 16'($urandom % 380);
      tbl[2] = 16'h0186;
      serve = 1'b1;
      for (k = 0; k < 3; k++) begin
         half = tbl[k];
         hold_chk(0, 1'b1, 2500, "served");
      end
      band = 1'b1;
      hold_chk(1, 1'b1, 100 + $urandom % 800, "short_band");
      band = 1'b0;
      hold_chk(1, 1'b1, 2200, "short_band_after");
      band = 1'b1;
      wait_for(1, 1'b0, 1000, 5000, "disable_time");
      serve = 1'b0;
      hold_chk(0, 1'b1, 3000, "disabled_high");
      band = 1'b0;
      wait_for(1, 1'b1, 1000, 5000, "enable_time");
      wait_for(0, 1'b0, lo_of(IG + TR), hi_of(IG + TR + 1), "reenable_miss");
      print_verdict();
   end
endmodule

`default_nettype wire
